// ### logic/ifm_irq_logic.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "ifm_consts.svh"
module ifm_irq_logic #(
   parameter int PORT_W = 6,
   parameter int PC_W   = 13
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire logic              external_interrupt_pin,
   input  wire logic [PORT_W-1:0] port_pins,
   input  wire logic              port_read,
   input  wire logic              timer0_rollover,
   input  wire logic              adc_done,
   input  wire logic              sleep_enter,
   input  wire logic              return_from_interrupt,
   input  wire logic [PC_W-1:0]   stack_pc,
   input  wire logic [PC_W-1:0]   next_pc,
   output logic                   core_irq,
   output logic                   wake_up,
   output logic                   push_pc,
   output logic      [PC_W-1:0]   push_value,
   output logic                   load_pc,
   output logic      [PC_W-1:0]   load_value,
   output logic                   dummy_cycle,
   output logic      [1:0]        q_phase
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   ifm_pkg::ifm_phase_t phase_reg,   phase_next;
   ifm_pkg::ifm_state_t state_reg,   state_next;
   logic [7:0]          intc_reg,    intc_next;
   logic [7:0]          pflag_reg,   pflag_next;
   logic [7:0]          pen_reg,     pen_next;
   logic [7:0]          opt_reg,     opt_next;
   logic [PORT_W-1:0]   sel_reg,     sel_next;
   logic [PORT_W-1:0]   latch_reg,   latch_next;
   logic                pin_reg,     pin_next;
   logic                sleep_reg,   sleep_next;
   logic                wake_en_reg, wake_en_next;
   logic [1:0]          dcnt_reg,    dcnt_next;
   logic [7:0]          rdata_reg,   rdata_next;
   logic                irq_reg,     irq_next;
   logic                wake_reg,    wake_next;
   logic                push_reg,    push_next;
   logic                load_reg,    load_next;
   logic                dummy_reg,   dummy_next;
   logic [PC_W-1:0]     pushv_reg,   pushv_next;
   logic [PC_W-1:0]     loadv_reg,   loadv_next;

   // ----------------------------------------
   // Request forming, shared by entry and wake
   // ----------------------------------------
   function automatic logic pending(input logic [7:0] ic, input logic [7:0] pf,
                                    input logic [7:0] pe);
      logic core_pair;
      logic per_pair;
      core_pair = (ic[`IFM_BIT_EXTIE] & ic[`IFM_BIT_EXTIF]) |
                  (ic[`IFM_BIT_TIMER_EN] & ic[`IFM_BIT_TIMER_FLAG]) |
                  (ic[`IFM_BIT_PCIE] & ic[`IFM_BIT_PCIF]);
      per_pair  = |(pf & pe & `IFM_PER_MASK);
      return core_pair | (ic[`IFM_BIT_GROUP_EN] & per_pair);
   endfunction

   // ----------------------------------------
   // Combinational helpers
   // ----------------------------------------
   logic       edge_hit;
   logic       change_hit;
   logic       req_any;
   logic       wake_req;
   logic [7:0] intc_w;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      phase_next   = ifm_pkg::ifm_phase_t'(phase_reg + 2'h1);
      state_next   = state_reg;
      intc_next    = intc_reg;
      pflag_next   = pflag_reg;
      pen_next     = pen_reg;
      opt_next     = opt_reg;
      sel_next     = sel_reg;
      latch_next   = latch_reg;
      pin_next     = pin_reg;
      sleep_next   = sleep_reg;
      wake_en_next = wake_en_reg;
      dcnt_next    = dcnt_reg;
      rdata_next   = 8'h00;
      push_next    = 1'b0;
      load_next    = 1'b0;
      pushv_next   = pushv_reg;
      loadv_next   = loadv_reg;
      dummy_next   = 1'b0;
      wake_next    = 1'b0;
      edge_hit     = 1'b0;
      change_hit   = 1'b0;
      wake_req     = 1'b0;
      intc_w       = intc_reg;

      // ----------------------------------------
      // External pin and port change
      // ----------------------------------------
      // Pin sampled only in Q1, so events land at the Q1-Q2 boundary
      if (phase_reg == ifm_pkg::IFM_Q1) begin
         pin_next = external_interrupt_pin;
         edge_hit = opt_reg[`IFM_BIT_EDGE] ? (external_interrupt_pin & ~pin_reg)
                                           : (~external_interrupt_pin & pin_reg);
      end
      // Port read at Q2 refreshes the latch and can mask a change
      // A change landing in the read cycle is lost; software must tolerate it
      change_hit = |((port_pins ^ latch_reg) & sel_reg);
      if (port_read && phase_reg == ifm_pkg::IFM_Q2) begin
         latch_next = port_pins;
         change_hit = 1'b0;
      end

      // ----------------------------------------
      // Register access
      // ----------------------------------------
      // Register writes first; hardware sets below win over clears
      if (reg_wr) begin
         unique case (reg_addr)
            `IFM_OFS_INT_CTRL:  intc_w     = reg_wdata;
            `IFM_OFS_PER_FLAGS: pflag_next = reg_wdata & `IFM_PER_MASK;
            `IFM_OFS_PER_EN:    pen_next   = reg_wdata & `IFM_PER_MASK;
            `IFM_OFS_OPTION:    opt_next   = reg_wdata;
            `IFM_OFS_CHG_SEL:   sel_next   = reg_wdata[PORT_W-1:0];
            default:            ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `IFM_OFS_INT_CTRL:  rdata_next = intc_reg;
            `IFM_OFS_PER_FLAGS: rdata_next = pflag_reg;
            `IFM_OFS_PER_EN:    rdata_next = pen_reg;
            `IFM_OFS_OPTION:    rdata_next = opt_reg;
            `IFM_OFS_CHG_SEL:   rdata_next = 8'(sel_reg);
            default:            rdata_next = 8'h00;
         endcase
      end

      // ----------------------------------------
      // Event flags
      // ----------------------------------------
      // Flags ignore all enables
      // A set in the same cycle as a software clear wins, so no event is lost
      if (edge_hit)        intc_w[`IFM_BIT_EXTIF] = 1'b1;
      if (timer0_rollover) intc_w[`IFM_BIT_TIMER_FLAG] = 1'b1;
      if (change_hit)      intc_w[`IFM_BIT_PCIF]  = 1'b1;
      if (adc_done)        pflag_next[`IFM_BIT_ADC] = 1'b1;
      if (return_from_interrupt) begin
         intc_w[`IFM_BIT_GLOBAL_EN] = 1'b1;
         load_next            = 1'b1;
         loadv_next           = stack_pc;
      end
      intc_next = intc_w;

      req_any = pending(intc_reg, pflag_reg, pen_reg);

      // ----------------------------------------
      // Sleep and wake-up
      // ----------------------------------------
      // Wake ignores global enable; the pin also needs its enable from before sleep
      wake_req = pending(intc_reg & ~(8'h01 << `IFM_BIT_EXTIF), pflag_reg, pen_reg) |
                 (intc_reg[`IFM_BIT_EXTIE] & intc_reg[`IFM_BIT_EXTIF] & wake_en_reg);
      if (sleep_enter) begin
         sleep_next   = 1'b1;
         wake_en_next = intc_reg[`IFM_BIT_EXTIE];
      end
      if (sleep_reg && wake_req) begin
         sleep_next = 1'b0;
         wake_next  = 1'b1;
      end

      // ----------------------------------------
      // Entry sequencer, advances per instruction cycle at Q4
      // ----------------------------------------
      unique case (state_reg)
         ifm_pkg::IFM_RUN: begin
            if (req_any && intc_reg[`IFM_BIT_GLOBAL_EN] && !sleep_reg
                && phase_reg == ifm_pkg::IFM_Q4) begin
               state_next = ifm_pkg::IFM_PEND;
            end
         end
         ifm_pkg::IFM_PEND: begin
            if (phase_reg == ifm_pkg::IFM_Q4) begin
               state_next = ifm_pkg::IFM_DUMMY;
               // Global enable drops with the push, so nothing re-enters in dummies
               dcnt_next  = `IFM_DUMMY_CYCLES;
               intc_next[`IFM_BIT_GLOBAL_EN] = 1'b0;
               push_next  = 1'b1;
               pushv_next = next_pc;
            end
         end
         ifm_pkg::IFM_DUMMY: begin
            dummy_next = 1'b1;
            if (phase_reg == ifm_pkg::IFM_Q4) begin
               dcnt_next = dcnt_reg - 2'h1;
               if (dcnt_reg == 2'h1) begin
                  state_next = ifm_pkg::IFM_RUN;
                  load_next  = 1'b1;
                  loadv_next = PC_W'(`IFM_VECTOR);
               end
            end
         end
         default: state_next = ifm_pkg::IFM_RUN;
      endcase

      irq_next = req_any & intc_reg[`IFM_BIT_GLOBAL_EN];
   end

   // ----------------------------------------
   // Registering
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_reg   <= ifm_pkg::IFM_Q1;
         state_reg   <= ifm_pkg::IFM_RUN;
         intc_reg    <= `IFM_RST_INT_CTRL;
         pflag_reg   <= `IFM_RST_PER;
         pen_reg     <= `IFM_RST_PER;
         // Option resets to all ones, so the pin starts on rising edges
         opt_reg     <= `IFM_RST_OPTION;
         sel_reg     <= '0;
         latch_reg   <= '0;
         pin_reg     <= 1'b0;
         sleep_reg   <= 1'b0;
         wake_en_reg <= 1'b0;
         dcnt_reg    <= 2'h0;
         rdata_reg   <= 8'h00;
         irq_reg     <= 1'b0;
         wake_reg    <= 1'b0;
         push_reg    <= 1'b0;
         load_reg    <= 1'b0;
         dummy_reg   <= 1'b0;
         pushv_reg   <= '0;
         loadv_reg   <= '0;
      end else begin
         phase_reg   <= phase_next;
         state_reg   <= state_next;
         intc_reg    <= intc_next;
         pflag_reg   <= pflag_next;
         pen_reg     <= pen_next;
         opt_reg     <= opt_next;
         sel_reg     <= sel_next;
         latch_reg   <= latch_next;
         pin_reg     <= pin_next;
         sleep_reg   <= sleep_next;
         wake_en_reg <= wake_en_next;
         dcnt_reg    <= dcnt_next;
         rdata_reg   <= rdata_next;
         irq_reg     <= irq_next;
         wake_reg    <= wake_next;
         push_reg    <= push_next;
         load_reg    <= load_next;
         dummy_reg   <= dummy_next;
         pushv_reg   <= pushv_next;
         loadv_reg   <= loadv_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // All straight from flip-flops, so the core sees no decode glitches
   assign reg_rdata   = rdata_reg;
   assign core_irq    = irq_reg;
   assign wake_up     = wake_reg;
   assign push_pc     = push_reg;
   assign push_value  = pushv_reg;
   assign load_pc     = load_reg;
   assign load_value  = loadv_reg;
   assign dummy_cycle = dummy_reg;
   assign q_phase     = phase_reg;
endmodule

// ### logic/ifm_consts.svh
`ifndef IFM_CONSTS_SVH
`define IFM_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IFM_OFS_INT_CTRL   8'h0B
`define IFM_OFS_PER_FLAGS  8'h0C
`define IFM_OFS_OPTION     8'h81
`define IFM_OFS_PER_EN     8'h8C
`define IFM_OFS_CHG_SEL    8'h96
// ----------------------------------------
// Field positions
// ----------------------------------------
`define IFM_BIT_GLOBAL_EN  7
`define IFM_BIT_GROUP_EN   6
`define IFM_BIT_TIMER_EN   5
`define IFM_BIT_EXTIE      4
`define IFM_BIT_PCIE       3
`define IFM_BIT_TIMER_FLAG 2
`define IFM_BIT_EXTIF      1
`define IFM_BIT_PCIF       0
`define IFM_BIT_EDGE       6
`define IFM_BIT_ADC        6
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define IFM_RST_INT_CTRL   8'h00
`define IFM_RST_PER        8'h00
`define IFM_RST_OPTION     8'hFF
`define IFM_RST_CHG_SEL    8'h00
`define IFM_PER_MASK       8'hC9
`define IFM_VECTOR         13'h0004
`define IFM_DUMMY_CYCLES   2'h2
`endif

// ### logic/ifm_pkg.sv
package ifm_pkg;
   typedef enum logic [1:0] {
      IFM_Q1,
      IFM_Q2,
      IFM_Q3,
      IFM_Q4
   } ifm_phase_t;

   typedef enum logic [1:0] {
      IFM_RUN,
      IFM_PEND,
      IFM_DUMMY
   } ifm_state_t;
endpackage

// ### verification/ifm_irq_logic_props.sv
`timescale 1ns/1ps
// ----
// Phase, entry and return checks
// ----
module ifm_irq_logic_props #(
   parameter int PC_W = 13
) (
   input wire logic            ref_clk,
   input wire logic            rst_n,
   input wire logic [7:0]      reg_addr,
   input wire logic [7:0]      reg_wdata,
   input wire logic            reg_wr,
   input wire logic            return_from_interrupt,
   input wire logic [PC_W-1:0] stack_pc,
   input wire logic [PC_W-1:0] next_pc,
   input wire logic            core_irq,
   input wire logic            push_pc,
   input wire logic [PC_W-1:0] push_value,
   input wire logic            load_pc,
   input wire logic [PC_W-1:0] load_value,
   input wire logic            dummy_cycle,
   input wire logic [1:0]      q_phase
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_phase_step: assert property ($past(rst_n) |-> q_phase == 2'($past(q_phase) + 2'h1))
      else $error("phase skipped");
   chk_push_value: assert property (push_pc |-> push_value == $past(next_pc))
      else $error("bad return value");
   chk_vector_load: assert property (
      load_pc && !$past(return_from_interrupt) |-> load_value == 13'h0004)
      else $error("bad vector");
   chk_dummy_len: assert property ($rose(dummy_cycle) |-> dummy_cycle [*8] ##1 !dummy_cycle)
      else $error("bad dummy length");
   chk_push_load: assert property (push_pc |-> ##[1:12] load_pc)
      else $error("no vector load");
   chk_return_load: assert property (
      return_from_interrupt |=> load_pc && load_value == $past(stack_pc))
      else $error("bad return load");
   chk_gie_off: assert property (
      reg_wr && reg_addr == 8'h0B && !reg_wdata[7] |-> ##2 !core_irq)
      else $error("request while masked");
   chk_entry_mask: assert property (push_pc |-> ##1 !core_irq)
      else $error("global enable kept");
endmodule
bind ifm_irq_logic ifm_irq_logic_props #(.PC_W(PC_W)) i_ifm_irq_logic_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .return_from_interrupt(return_from_interrupt), .stack_pc(stack_pc),
   .next_pc(next_pc), .core_irq(core_irq), .push_pc(push_pc), .push_value(push_value),
   .load_pc(load_pc), .load_value(load_value), .dummy_cycle(dummy_cycle), .q_phase(q_phase));

// ### verification/ifm_core_model.sv
`timescale 1ns/1ps
// ----
// Core sequencer stand-in
// ----
module ifm_core_model #(
   parameter int PC_W = 13
) (
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   input  wire logic [1:0]      q_phase,
   input  wire logic            push_pc,
   input  wire logic [PC_W-1:0] push_value,
   input  wire logic            load_pc,
   input  wire logic [PC_W-1:0] load_value,
   output logic      [PC_W-1:0] next_pc,
   output logic      [PC_W-1:0] stack_pc
);
   // One stack level only, enough for a single nesting
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         next_pc <= '0;
         stack_pc <= '0;
      end else begin
         if (load_pc)
            next_pc <= load_value;
         else if (q_phase == 2'h3)
            next_pc <= next_pc + 1'b1;
         if (push_pc)
            stack_pc <= push_value;
      end
   end
endmodule

// ### verification/ifm_irq_logic_bench.sv
`timescale 1ns/1ps
module ifm_irq_logic_bench;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        pin = 1'b0;
   logic [5:0]  port_pins = 6'h00;
   logic        port_read = 1'b0;
   logic [3:0]  ev = 4'h0;
   logic [7:0]  reg_rdata;
   logic        core_irq, wake_up, push_pc, load_pc, dummy_cycle;
   logic [12:0] next_pc, stack_pc, push_value, load_value;
   logic [1:0]  q_phase;
   int          mismatches = 0;
   int          num_checks = 0;
   int          loads = 0;
   int          wakes = 0;
   int          i;
   localparam logic [15:0] ROWS [6] = '{16'h0B00, 16'h0C00, 16'h81FF, 16'h8C00,
                                       16'h9600, 16'h5500};
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (load_pc) loads <= loads + 1;
   always @(posedge ref_clk) if (wake_up) wakes <= wakes + 1;
   ifm_irq_logic #(.PORT_W(6), .PC_W(13)) i_ifm_irq_logic (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_interrupt_pin(pin), .port_pins(port_pins), .port_read(port_read),
      .timer0_rollover(ev[0]), .adc_done(ev[1]), .return_from_interrupt(ev[2]),
      .sleep_enter(ev[3]), .stack_pc(stack_pc), .next_pc(next_pc), .core_irq(core_irq),
      .wake_up(wake_up), .push_pc(push_pc), .push_value(push_value), .load_pc(load_pc),
      .load_value(load_value), .dummy_cycle(dummy_cycle), .q_phase(q_phase));
   ifm_core_model #(.PC_W(13)) i_ifm_core_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .q_phase(q_phase), .push_pc(push_pc),
      .push_value(push_value), .load_pc(load_pc), .load_value(load_value),
      .next_pc(next_pc), .stack_pc(stack_pc));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge ref_clk);
      ev <= m;
      @(posedge ref_clk);
      ev <= 4'h0;
   endtask
   // Pin is only looked at once per Q1, so give it two whole cycles
   task automatic settle;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic wt(input bit w);
      int n;
      n = 0;
      while ((w ? wake_up : load_pc) !== 1'b1 && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      if ((w ? wake_up : load_pc) !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk);
      mismatches++;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i++) begin
         rd(ROWS[i][15:8], ROWS[i][7:0]);
      end
      @(posedge ref_clk) pin <= 1'b1;
      settle;
      rd(8'h0B, 8'h02);
      wr(8'h0B, 8'h82);
      settle;
      #1 chk({15'h0, core_irq}, 16'h0000);
      wr(8'h0B, 8'h00);
      wr(8'h81, 8'hBF);
      @(posedge ref_clk) pin <= 1'b0;
      settle;
      rd(8'h0B, 8'h02);
      wr(8'h0B, 8'h00);
      @(posedge ref_clk) pin <= 1'b1;
      settle;
      rd(8'h0B, 8'h00);
      pulse(4'h1);
      rd(8'h0B, 8'h04);
      wr(8'h0B, 8'hA4);
      @(posedge ref_clk);
      #1 chk({15'h0, core_irq}, 16'h0001);
      wt(1'b0);
      chk({3'h0, load_value}, 16'h0004);
      wr(8'h0B, 8'h00);
      wr(8'h96, 8'h01);
      @(posedge ref_clk) port_pins <= 6'h02;
      settle;
      rd(8'h0B, 8'h00);
      @(posedge ref_clk) port_pins <= 6'h03;
      settle;
      rd(8'h0B, 8'h01);
      @(posedge ref_clk) port_pins <= 6'h00;
      settle;
      wr(8'h0B, 8'h00);
      // Change lands in the same Q2 as a port read, so it is lost
      @(negedge ref_clk);
      while (q_phase !== 2'h0) @(negedge ref_clk);
      @(posedge ref_clk);
      port_pins <= 6'h01;
      port_read <= 1'b1;
      @(posedge ref_clk) port_read <= 1'b0;
      settle;
      rd(8'h0B, 8'h00);
      pulse(4'h2);
      rd(8'h0C, 8'h40);
      wr(8'h8C, 8'h40);
      wr(8'h0B, 8'hC0);
      wt(1'b0);
      chk({3'h0, load_value}, 16'h0004);
      rd(8'h0B, 8'h40);
      wr(8'h0C, 8'h00);
      pulse(4'h4);
      rd(8'h0B, 8'hC0);
      wr(8'h0B, 8'h10);
      pulse(4'h8);
      i = loads;
      @(posedge ref_clk) pin <= 1'b0;
      wt(1'b1);
      chk({15'h0, wake_up}, 16'h0001);
      settle;
      #1 chk(loads[15:0], i[15:0]);
      // Enable set only after sleep: the pin edge must not wake
      wr(8'h0B, 8'h00);
      pulse(4'h8);
      wr(8'h0B, 8'h10);
      i = wakes;
      @(posedge ref_clk) pin <= 1'b1;
      settle;
      @(posedge ref_clk) pin <= 1'b0;
      settle;
      rd(8'h0B, 8'h12);
      #1 chk(wakes[15:0], i[15:0]);
      finish_test;
   end
endmodule
